// >>> design/scp_cfg.svh
// constants for the serial control port pin select block
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH

// fixed upper nibble of the seven-bit target address
`define SCP_ADDR_HIGH 4'hd
// target address reported while the port runs as an spi target
`define SCP_ADDR_NONE 7'h00
// strap level that selects each protocol
`define SCP_STRAP_I2C 1'b0
`define SCP_STRAP_SPI 1'b1
// select pin level that frames an spi access
`define SCP_SELECT_ACTIVE 1'b0
// bits per serial byte
`define SCP_BYTE_BITS 8
// synchroniser depth
`define SCP_SYNC_STAGES 2

`endif

// >>> design/scp_pkg.sv
// types shared by the serial control port pin select block
package scp_pkg;

  typedef enum logic [1:0] {
    SCP_PROTO_I2C = 2'b01,
    SCP_PROTO_SPI = 2'b10
  } scp_proto_t;

  typedef enum logic [1:0] {
    SCP_PH_LATCH = 2'b01,
    SCP_PH_RUN = 2'b10
  } scp_phase_t;

endpackage

// >>> design/scp_sync2.sv
// two flip-flop level synchroniser with asynchronous clear
`timescale 1ns/100ps
`include "scp_cfg.svh"

module scp_sync2 #(
  parameter int Width = 1
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [Width-1:0] dIn,
  output logic [Width-1:0] qOut
);

  logic [Width-1:0] firstReg;
  logic [Width-1:0] secondReg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      firstReg <= '0;
      secondReg <= '0;
    end else begin
      firstReg <= dIn;
      secondReg <= firstReg;
    end
  end

  assign qOut = secondReg;

endmodule

// >>> design/scp_pin_select.sv
// serial control port pin select: strap-driven i2c or spi target pin roles
// Contract
// - strap low gives i2c target, strap high gives spi target
// - host drives serial clock; device shifts on it in both modes
// - spi: shared data pin is only the serial data output
// - i2c address is 1101 followed by straps two, one, zero
// - spi: address straps zero and one are ignored
// - i2c: address/select pin is the top hardware address bit
// - spi: address/select pin is the slave select framing accesses
// - spi: command, address and write data arrive on spi input pin
// - i2c: spi input pin is ignored
`timescale 1ns/100ps
`include "scp_cfg.svh"

module scp_pin_select
  import scp_pkg::*;
#(
  parameter int ByteBits = `SCP_BYTE_BITS
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic linkSclk,
  input wire logic port_protocol_strap,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap2_or_select,
  input wire logic spi_serial_in_pin,
  input wire logic sharedSerialDataIn,
  output logic sharedSerialDataOut,
  output logic sharedSerialDataOe,
  input wire logic [ByteBits-1:0] txByte,
  input wire logic txLoad,
  input wire logic txEnable,
  output logic protoIsSpi,
  output logic configDone,
  output logic [6:0] targetAddr,
  output logic spiSelected,
  output logic [ByteBits-1:0] rxByte,
  output logic rxStrobe
);

  localparam int CntW = $clog2(ByteBits);
  localparam logic [CntW-1:0] LastBit = CntW'(ByteBits - 1);

  // ==========================================================
  // reset release
  logic [1:0] rstPipeReg;
  logic rstSyncN;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipeReg <= 2'h0;
    end else begin
      rstPipeReg <= {rstPipeReg[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipeReg[1];

  // ==========================================================
  // strap sampling in the system domain
  logic [3:0] strapSync;
  logic strapSpi;
  logic a0Sync;
  logic a1Sync;
  logic a2SelSync;

  scp_sync2 #(.Width(4)) uStrapSync (
    .clk(sys_clk),
    .rstN(rstSyncN),
    .dIn({port_protocol_strap, addr_strap2_or_select, addr_strap_bit1, addr_strap_bit0}),
    .qOut(strapSync)
  );
  assign strapSpi = strapSync[3];
  assign a2SelSync = strapSync[2];
  assign a1Sync = strapSync[1];
  assign a0Sync = strapSync[0];

  // ==========================================================
  // protocol latch
  scp_phase_t phaseReg;
  scp_proto_t protoReg;
  logic [1:0] settleReg;

  // waits for the synchroniser to fill, then freezes the choice; a later
  // disturbance on the strap cannot swap pin roles mid transfer
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      phaseReg <= SCP_PH_LATCH;
      protoReg <= SCP_PROTO_I2C;
    end else begin
      unique case (phaseReg)
        SCP_PH_LATCH: begin
          // synchroniser output is still its reset value before this count
          if (settleReg == 2'h2) begin
            phaseReg <= SCP_PH_RUN;
            protoReg <= (strapSpi == `SCP_STRAP_SPI) ? SCP_PROTO_SPI : SCP_PROTO_I2C;
          end
        end
        SCP_PH_RUN: begin
          phaseReg <= SCP_PH_RUN;
        end
      endcase
    end
  end

  // the latch phase lasts three cycles, until the two synchroniser stages have filled; the count then stops at 3
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      settleReg <= 2'h0;
    end else if (settleReg != 2'h3) begin
      settleReg <= settleReg + 2'h1;
    end
  end

  logic spiMode;
  assign spiMode = (protoReg == SCP_PROTO_SPI);

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      protoIsSpi <= 1'b0;
      configDone <= 1'b0;
    end else begin
      protoIsSpi <= spiMode;
      configDone <= (phaseReg == SCP_PH_RUN) && (settleReg == 2'h3);
    end
  end

  // ==========================================================
  // address and select decode
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      targetAddr <= `SCP_ADDR_NONE;
      spiSelected <= 1'b0;
    end else if (spiMode) begin
      targetAddr <= `SCP_ADDR_NONE;
      spiSelected <= (a2SelSync == `SCP_SELECT_ACTIVE);
    end else begin
      targetAddr <= {`SCP_ADDR_HIGH, a2SelSync, a1Sync, a0Sync};
      spiSelected <= 1'b0;
    end
  end

  // ==========================================================
  // transmit hold, handed over by toggle
  logic [ByteBits-1:0] txHoldReg;
  logic txToggleReg;

  // txByte is sampled on txLoad; txHoldReg then holds it until the next txLoad
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      txHoldReg <= '0;
      txToggleReg <= 1'b0;
    end else if (txLoad) begin
      txHoldReg <= txByte;
      txToggleReg <= ~txToggleReg;
    end
  end

  // ==========================================================
  // link domain: serial clock from the host
  logic [0:0] linkRstSync;
  logic linkRstN;
  logic [2:0] linkCtl;
  logic linkSpi;
  logic linkTxToggle;
  logic linkTxEn;
  logic frameClrN;

  scp_sync2 #(.Width(1)) uLinkRst (
    .clk(linkSclk),
    .rstN(rst_n),
    .dIn(1'b1),
    .qOut(linkRstSync)
  );
  assign linkRstN = linkRstSync[0];

  scp_sync2 #(.Width(3)) uLinkCtl (
    .clk(linkSclk),
    .rstN(linkRstN),
    .dIn({spiMode, txToggleReg, txEnable}),
    .qOut(linkCtl)
  );
  assign linkSpi = linkCtl[2];
  assign linkTxToggle = linkCtl[1];
  assign linkTxEn = linkCtl[0];

  // deselect ends the frame even with the serial clock stopped
  assign frameClrN = linkRstN & ~(linkSpi & (addr_strap2_or_select != `SCP_SELECT_ACTIVE));

  logic serialBit;
  // mode picks which pin feeds the shifter; the other is never looked at
  assign serialBit = linkSpi ? spi_serial_in_pin : sharedSerialDataIn;

  logic [ByteBits-1:0] rxShiftReg;
  logic [ByteBits-1:0] rxHoldReg;
  logic [CntW-1:0] bitCntReg;
  logic rxToggleReg;

  always_ff @(posedge linkSclk or negedge frameClrN) begin
    if (!frameClrN) begin
      rxShiftReg <= '0;
      bitCntReg <= '0;
    end else begin
      rxShiftReg <= {rxShiftReg[ByteBits-2:0], serialBit};
      bitCntReg <= (bitCntReg == LastBit) ? '0 : bitCntReg + 1'b1;
    end
  end

  always_ff @(posedge linkSclk or negedge linkRstN) begin
    if (!linkRstN) begin
      rxHoldReg <= '0;
      rxToggleReg <= 1'b0;
    end else if (frameClrN && bitCntReg == LastBit) begin
      rxHoldReg <= {rxShiftReg[ByteBits-2:0], serialBit};
      rxToggleReg <= ~rxToggleReg;
    end
  end

  // ==========================================================
  // link domain: data pin drive, launched on the falling edge
  logic [ByteBits-1:0] txShiftReg;
  logic [ByteBits-1:0] txValidReg;
  logic txSeenReg;
  logic txTake;

  // a new byte is taken only at a byte boundary inside a live frame
  assign txTake = frameClrN && (bitCntReg == '0) && (txSeenReg != linkTxToggle);

  // survives a deselect so a byte is never sent twice
  always_ff @(negedge linkSclk or negedge linkRstN) begin
    if (!linkRstN) begin
      txSeenReg <= 1'b0;
    end else if (txTake) begin
      txSeenReg <= linkTxToggle;
    end
  end

  always_ff @(negedge linkSclk or negedge frameClrN) begin
    if (!frameClrN) begin
      txShiftReg <= '0;
      txValidReg <= '0;
      sharedSerialDataOut <= 1'b0;
      sharedSerialDataOe <= 1'b0;
    end else begin
      // valid mask marks live bits; an empty shifter leaves the i2c line released
      if (txTake) begin
        txShiftReg <= txHoldReg;
        txValidReg <= '1;
      end else begin
        txShiftReg <= {txShiftReg[ByteBits-2:0], 1'b0};
        txValidReg <= {txValidReg[ByteBits-2:0], 1'b0};
      end
      if (linkSpi) begin
        sharedSerialDataOut <= txShiftReg[ByteBits-1];
        sharedSerialDataOe <= 1'b1;
      end else begin
        // open drain: only ever pull low
        sharedSerialDataOut <= 1'b0;
        sharedSerialDataOe <= linkTxEn & txValidReg[ByteBits-1] & ~txShiftReg[ByteBits-1];
      end
    end
  end

  // ==========================================================
  // received byte back into the system domain
  logic [0:0] rxTogSync;
  logic rxTogSeenReg;

  scp_sync2 #(.Width(1)) uRxTog (
    .clk(sys_clk),
    .rstN(rstSyncN),
    .dIn(rxToggleReg),
    .qOut(rxTogSync)
  );

  // hold register is stable for a full byte after its toggle
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rxTogSeenReg <= 1'b0;
      rxStrobe <= 1'b0;
      rxByte <= '0;
    end else begin
      rxTogSeenReg <= rxTogSync[0];
      rxStrobe <= rxTogSync[0] ^ rxTogSeenReg;
      if (rxTogSync[0] ^ rxTogSeenReg) begin
        rxByte <= rxHoldReg;
      end
    end
  end

endmodule

// >>> testbench/scp_pin_select_chk.sv
// port assertions for the pin select block
`timescale 1ns/100ps
module scp_pin_select_chk #(
  parameter int ByteBits = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap2_or_select,
  input wire logic sharedSerialDataOut,
  input wire logic protoIsSpi,
  input wire logic configDone,
  input wire logic [6:0] targetAddr,
  input wire logic spiSelected,
  input wire logic rxStrobe
);
  // ==========
  // properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic i2cUp = configDone && !protoIsSpi;
  a_spi_addr_zero: assert property (protoIsSpi && $past(protoIsSpi, 2) |-> targetAddr == 7'h00)
    else $error("spi address not zero");
  a_i2c_addr_high: assert property (i2cUp && $past(configDone, 2) |-> targetAddr[6:3] == 4'hd)
    else $error("address nibble wrong");
  a_i2c_addr_low: assert property (i2cUp && $past(configDone, 3) |-> targetAddr[2:0] ==
    $past({addr_strap2_or_select, addr_strap_bit1, addr_strap_bit0}, 3))
    else $error("address straps wrong");
  a_spi_select: assert property (protoIsSpi && $past(protoIsSpi, 3) |->
    spiSelected == !$past(addr_strap2_or_select, 3))
    else $error("select not followed");
  a_i2c_no_select: assert property (i2cUp && $past(configDone, 2) |-> !spiSelected)
    else $error("select in i2c mode");
  a_i2c_out_low: assert property (i2cUp |-> !sharedSerialDataOut)
    else $error("i2c data out high");
  a_strobe_pulse: assert property (rxStrobe |=> !rxStrobe)
    else $error("strobe too long");
  a_proto_frozen: assert property (configDone |=> configDone && $stable(protoIsSpi))
    else $error("protocol changed");
endmodule

bind scp_pin_select scp_pin_select_chk #(.ByteBits(ByteBits)) uChk (.sys_clk(sys_clk),
  .rst_n(rst_n), .addr_strap_bit0(addr_strap_bit0), .addr_strap_bit1(addr_strap_bit1),
  .addr_strap2_or_select(addr_strap2_or_select), .sharedSerialDataOut(sharedSerialDataOut),
  .protoIsSpi(protoIsSpi), .configDone(configDone), .targetAddr(targetAddr),
  .spiSelected(spiSelected), .rxStrobe(rxStrobe));

// >>> testbench/scp_host_model.sv
// host controller model driving the serial clock and data lines
`timescale 1ns/100ps
module scp_host_model (
  output logic linkSclk,
  output logic selN,
  output logic spiIn,
  output logic sdaWire,
  input wire logic devOut,
  input wire logic devOe,
  input wire logic spiMode
);
  logic hostSda = 1'b1;
  initial linkSclk = 1'b0;
  initial selN = 1'b1;
  initial spiIn = 1'b0;
  // undriven spi output shows the inverse, not a kind stale value
  assign sdaWire = spiMode ? (devOe ? devOut : ~devOut) : ((devOe && !devOut) ? 1'b0 : hostSda);
  task automatic shift(input logic [23:0] bits, input int n, output logic [23:0] seen);
    seen = '0;
    if (spiMode) selN = 1'b0;
    #5;
    for (int i = n - 1; i >= 0; i--) begin
      spiIn = spiMode ? bits[i] : ~bits[i];
      hostSda = spiMode | bits[i];
      #6 linkSclk = 1'b1;
      seen = {seen[22:0], sdaWire};
      #6 linkSclk = 1'b0;
    end
    #5 selN = 1'b1;
    spiIn = 1'b0;
    hostSda = 1'b1;
    // idle gap so a following frame sees a real deselect
    #6;
  endtask
endmodule

// >>> testbench/tb_top.sv
// self-checking bench for the pin select block
`timescale 1ns/100ps
module tb_top;
  import scp_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, strap = 1'b1, a0 = 1'b0, a1 = 1'b0, a2 = 1'b0;
  logic txLoad = 1'b0, txEnable = 1'b1, linkSclk, selN, spiIn, sdaWire, sdo, oe;
  logic protoIsSpi, configDone, spiSelected, rxStrobe;
  logic [7:0] txByte = 8'h00, rxByte;
  logic [6:0] targetAddr;
  logic [23:0] seen;
  int mismatches = 0, checks_done = 0, seed = 32'h3cb0;
  wire logic a2Pin = strap ? selN : a2;
  always #10 sys_clk = ~sys_clk;
  scp_host_model host (.linkSclk(linkSclk), .selN(selN), .spiIn(spiIn), .sdaWire(sdaWire),
    .devOut(sdo), .devOe(oe), .spiMode(strap));
  scp_pin_select #(.ByteBits(8)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .linkSclk(linkSclk),
    .port_protocol_strap(strap), .addr_strap_bit0(a0), .addr_strap_bit1(a1),
    .addr_strap2_or_select(a2Pin), .spi_serial_in_pin(spiIn), .sharedSerialDataIn(sdaWire),
    .sharedSerialDataOut(sdo), .sharedSerialDataOe(oe), .txByte(txByte), .txLoad(txLoad),
    .txEnable(txEnable), .protoIsSpi(protoIsSpi), .configDone(configDone),
    .targetAddr(targetAddr), .spiSelected(spiSelected), .rxByte(rxByte), .rxStrobe(rxStrobe));
  // ==========
  // helpers
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic hasByte(input logic [23:0] s, input logic [7:0] b);
    for (int k = 0; k <= 16; k++) if (s[k +: 8] == b) return 1'b1;
    return 1'b0;
  endfunction
  task automatic doReset(input logic mode);
    @(negedge sys_clk);
    rst_n = 1'b0;
    strap = mode;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 20 && !configDone; i++) @(negedge sys_clk);
    check("proto", protoIsSpi, mode);
    host.shift(24'h0, 2, seen);
  endtask
  task automatic rxCheck(input logic [7:0] b);
    host.shift({16'h0, b}, 8, seen);
    for (int i = 0; i < 20 && !rxStrobe; i++) @(negedge sys_clk);
    check("rx", rxByte, b);
  endtask
  task automatic txCheck(input logic [23:0] bits);
    txByte = 8'($random(seed)) | 8'h81;
    txLoad = 1'b1;
    @(negedge sys_clk);
    txLoad = 1'b0;
    host.shift(bits, 24, seen);
    @(negedge sys_clk);
    check("tx", hasByte(seen, txByte), 1);
  endtask
  // ==========
  // scenarios
  initial begin
    doReset(1'b1);
    rxCheck(8'hff);
    for (int i = 0; i < 3; i++) begin
      {a1, a0} = 2'($random(seed));
      host.shift(24'h5, 3, seen);
      fork
        rxCheck(8'($random(seed)));
        begin
          repeat (4) @(negedge sys_clk);
          check("selected", spiSelected, 1);
        end
      join
      check("spi addr", targetAddr, 0);
    end
    txCheck(24'h0);
    doReset(1'b0);
    rxCheck(8'h00);
    for (int i = 0; i < 4; i++) begin
      {a2, a1, a0} = 3'($random(seed));
      repeat (4) @(negedge sys_clk);
      check("i2c addr", targetAddr, {4'hd, a2, a1, a0});
      check("unselected", spiSelected, 0);
      rxCheck(8'($random(seed)));
    end
    txCheck(24'hffffff);
    txEnable = 1'b0;
    txLoad = 1'b1;
    @(negedge sys_clk);
    txLoad = 1'b0;
    host.shift(24'hffffff, 24, seen);
    @(negedge sys_clk);
    check("released", seen[7:0] & seen[15:8] & seen[23:16], 8'hff);
    strap = 1'b1;
    repeat (5) @(negedge sys_clk);
    check("frozen", protoIsSpi, 0);
    summarize();
  end
  initial begin
    #50000;
    mismatches++;
    summarize();
  end
endmodule
